/* File: src/tsr_pkg.sv */
package tsr_pkg;
    localparam int TSR_CW = 24;
    localparam int TSR_AW = 16;
    // register byte addresses
    localparam logic [15:0] TSR_CMP_L = 16'ha018;
    localparam logic [15:0] TSR_CMP_M = 16'ha019;
    localparam logic [15:0] TSR_CMP_H = 16'ha01a;
    localparam logic [15:0] TSR_CTRL = 16'ha020;
    localparam logic [15:0] TSR_STAT = 16'ha021;
    localparam logic [15:0] TSR_CNT_L = 16'ha102;
    localparam logic [15:0] TSR_CNT_M = 16'ha103;
    localparam logic [15:0] TSR_CNT_H = 16'ha104;
    localparam logic [15:0] TSR_RL_L = 16'ha105;
    localparam logic [15:0] TSR_RL_M = 16'ha106;
    localparam logic [15:0] TSR_RL_H = 16'ha107;
    localparam logic [15:0] TSR_SS0_L = 16'ha110;
    localparam logic [15:0] TSR_SS0_M = 16'ha111;
    localparam logic [15:0] TSR_SS0_H = 16'ha112;
    localparam logic [15:0] TSR_SS1_L = 16'ha113;
    localparam logic [15:0] TSR_SS1_M = 16'ha114;
    localparam logic [15:0] TSR_SS1_H = 16'ha115;
    localparam logic [15:0] TSR_SSC = 16'ha117;
    // trigger control fields
    localparam int TSR_SSC_STB0 = 7;
    localparam int TSR_SSC_STB1 = 6;
    localparam int TSR_SSC_SEL0 = 5;
    localparam int TSR_SSC_SEL1 = 4;
    // own control register fields
    localparam int TSR_CTL_RUN = 0;
    localparam int TSR_CTL_AUTO = 1;
    localparam int TSR_CTL_INIT = 2;
    localparam int TSR_CTL_CMP1EN = 3;
    localparam int TSR_STAT_CMP1F = 0;
    localparam logic [7:0] TSR_RST8 = 8'h00;
    localparam logic [23:0] TSR_RST24 = 24'h00_0000;
    localparam logic [23:0] TSR_ALL1 = 24'hff_ffff;
    localparam logic [31:0] TSR_RD0 = 32'h0000_0000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [15:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } tsr_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } tsr_wb_rsp_t;
endpackage

/* File: src/tsr_snap.sv */
`timescale 1ns/1ps
`default_nettype none
module tsr_snap #(
    parameter int W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_i,
    input wire logic sw_sel_i,
    input wire logic sw_stb_i,
    input wire logic [W-1:0] count_i,
    output logic [W-1:0] snap_o,
    output logic cap_o
);
    import tsr_pkg::*;
    logic irq_q_r;
    logic hw_evt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q_r <= 1'b0;
        end else begin
            irq_q_r <= irq_i;
        end
    end
    // one capture per rising edge of the level
    assign hw_evt = irq_i & ~irq_q_r;
    assign cap_o = sw_sel_i ? sw_stb_i : hw_evt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            snap_o <= '0;
        end else if (cap_o) begin
            snap_o <= count_i;
        end
    end

    property p_snap_take;
        @(posedge clk_i) disable iff (rst_i) cap_o |=> snap_o == $past(count_i);
    endproperty
    a_snap_take: assert property (p_snap_take) else $error("snapshot not taken");
    property p_snap_hold;
        @(posedge clk_i) disable iff (rst_i) !cap_o |=> $stable(snap_o);
    endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("snapshot changed");
    property p_one_per_evt;
        @(posedge clk_i) disable iff (rst_i) (!sw_sel_i && cap_o) ##1 !sw_sel_i |-> !cap_o;
    endproperty
    a_one_per_evt: assert property (p_one_per_evt) else $error("repeat capture");
    property p_sw_ignores_hw;
        @(posedge clk_i) disable iff (rst_i) (sw_sel_i && !sw_stb_i) |-> !cap_o;
    endproperty
    a_sw_ignores_hw: assert property (p_sw_ignores_hw) else $error("hw capture in sw mode");
    c_hw_cap: cover property (@(posedge clk_i) disable iff (rst_i) !sw_sel_i && cap_o);
endmodule // tsr_snap
`default_nettype wire

/* File: src/tsr_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module tsr_counter #(
    parameter int W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic auto_i,
    input wire logic init_i,
    input wire logic init_sel_i,
    input wire logic [W-1:0] reload_i,
    output logic [W-1:0] count_o
);
    import tsr_pkg::*;
    logic [W-1:0] count_nxt;

    always_comb begin
        count_nxt = count_o;
        if (init_i) begin
            count_nxt = init_sel_i ? reload_i : '0;
        end else if (run_i) begin
            if (auto_i && (&count_o)) begin
                count_nxt = reload_i;
            end else begin
                count_nxt = count_o + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else begin
            count_o <= count_nxt;
        end
    end

    property p_init;
        @(posedge clk_i) disable iff (rst_i)
            init_i |=> count_o == ($past(init_sel_i) ? $past(reload_i) : '0);
    endproperty
    a_init: assert property (p_init) else $error("init load wrong");
    property p_reload;
        @(posedge clk_i) disable iff (rst_i)
            (!init_i && run_i && auto_i && (&count_o)) |=> count_o == $past(reload_i);
    endproperty
    a_reload: assert property (p_reload) else $error("auto reload wrong");
    property p_free;
        @(posedge clk_i) disable iff (rst_i)
            (!init_i && run_i && !auto_i) |=> count_o == $past(count_o) + 1'b1;
    endproperty
    a_free: assert property (p_free) else $error("count step wrong");
    property p_stop;
        @(posedge clk_i) disable iff (rst_i) (!init_i && !run_i) |=> $stable(count_o);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");
    c_reload: cover property (@(posedge clk_i) disable iff (rst_i)
        run_i && auto_i && (&count_o));
endmodule // tsr_counter
`default_nettype wire

/* File: src/tsr_top.sv */
// How it works
// - the live 24-bit count reads back as three bytes, always the current value.
// - a write to the count low byte stores nothing and reinitialises the whole count.
// - count middle and high bytes are read-only and writes to them do nothing.
// - a 24-bit read-write reload value over three bytes is both reload source and init value.
// - two 24-bit read-only snapshots each latch the count when triggered.
// - snapshot zero is triggered by software or by the interrupt-zero event, by its select bit.
// - snapshot one is triggered by software or by the interrupt-one event, by its select bit.
// - writing one to the zero strobe with software selected captures snapshot zero, self-clearing.
// - writing one to the one strobe with software selected captures snapshot one, self-clearing.
// - zero select at one honours the strobe and ignores interrupt zero, at zero the reverse.
// - one select at one honours the strobe and ignores interrupt one, at zero the reverse.
// - init select zero loads zero, one loads the reload value, on a low-byte write.
// - in auto-reload mode the count reloads from the reload value after all-ones.
// - an enabled compare one match sets a sticky flag and raises the timer interrupt.
`timescale 1ns/1ps
`default_nettype none
module tsr_top #(
    parameter int CW = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire tsr_pkg::tsr_wb_req_t wb_req_i,
    output tsr_pkg::tsr_wb_rsp_t wb_rsp_o,
    input wire logic ext_irq_zero_i,
    input wire logic ext_irq_one_i,
    output logic timer_irq_o,
    output logic [CW-1:0] timer_count_o
);
    import tsr_pkg::*;

    logic [CW-1:0] timer_count;
    logic [CW-1:0] reload_value_r;
    logic [CW-1:0] compare1_value_r;
    logic [CW-1:0] snapshot_zero;
    logic [CW-1:0] snapshot_one;
    logic snap_zero_sw_select_r;
    logic snap_one_sw_select_r;
    logic snap_zero_strobe_r;
    logic snap_one_strobe_r;
    logic run_r;
    logic auto_reload_mode_r;
    logic init_select_r;
    logic compare1_enable_r;
    logic compare1_match_flag_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;
    logic wr_go;
    logic rd_go;
    logic b0_wr;
    logic init_go;
    logic cmp_hit;
    logic flag_clr;
    logic cap0;
    logic cap1;
    logic [7:0] wd;

    // classic wishbone, one wait state, byte lane 0
    assign wd = wb_req_i.dat[7:0];
    assign b0_wr = wb_req_i.sel[0];
    assign wr_go = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~ack_r & b0_wr;
    assign rd_go = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~ack_r;
    assign init_go = wr_go && (wb_req_i.adr == TSR_CNT_L);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_req_i.cyc & wb_req_i.stb & ~ack_r;
        end
    end

    always_comb begin
        rdat_nxt = TSR_RD0;
        case (wb_req_i.adr)
            TSR_CMP_L: rdat_nxt[7:0] = compare1_value_r[7:0];
            TSR_CMP_M: rdat_nxt[7:0] = compare1_value_r[15:8];
            TSR_CMP_H: rdat_nxt[7:0] = compare1_value_r[23:16];
            TSR_CTRL: begin
                rdat_nxt[TSR_CTL_RUN] = run_r;
                rdat_nxt[TSR_CTL_AUTO] = auto_reload_mode_r;
                rdat_nxt[TSR_CTL_INIT] = init_select_r;
                rdat_nxt[TSR_CTL_CMP1EN] = compare1_enable_r;
            end
            TSR_STAT: rdat_nxt[TSR_STAT_CMP1F] = compare1_match_flag_r;
            TSR_CNT_L: rdat_nxt[7:0] = timer_count[7:0];
            TSR_CNT_M: rdat_nxt[7:0] = timer_count[15:8];
            TSR_CNT_H: rdat_nxt[7:0] = timer_count[23:16];
            TSR_RL_L: rdat_nxt[7:0] = reload_value_r[7:0];
            TSR_RL_M: rdat_nxt[7:0] = reload_value_r[15:8];
            TSR_RL_H: rdat_nxt[7:0] = reload_value_r[23:16];
            TSR_SS0_L: rdat_nxt[7:0] = snapshot_zero[7:0];
            TSR_SS0_M: rdat_nxt[7:0] = snapshot_zero[15:8];
            TSR_SS0_H: rdat_nxt[7:0] = snapshot_zero[23:16];
            TSR_SS1_L: rdat_nxt[7:0] = snapshot_one[7:0];
            TSR_SS1_M: rdat_nxt[7:0] = snapshot_one[15:8];
            TSR_SS1_H: rdat_nxt[7:0] = snapshot_one[23:16];
            TSR_SSC: begin
                rdat_nxt[TSR_SSC_SEL0] = snap_zero_sw_select_r;
                rdat_nxt[TSR_SSC_SEL1] = snap_one_sw_select_r;
            end
            default: rdat_nxt = TSR_RD0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_r <= TSR_RD0;
        end else if (rd_go) begin
            rdat_r <= rdat_nxt;
        end
    end

    assign wb_rsp_o.ack = ack_r;
    assign wb_rsp_o.dat = rdat_r;

    // reload and compare value bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_value_r <= TSR_RST24;
            compare1_value_r <= TSR_RST24;
        end else if (wr_go) begin
            case (wb_req_i.adr)
                TSR_RL_L: reload_value_r[7:0] <= wd;
                TSR_RL_M: reload_value_r[15:8] <= wd;
                TSR_RL_H: reload_value_r[23:16] <= wd;
                TSR_CMP_L: compare1_value_r[7:0] <= wd;
                TSR_CMP_M: compare1_value_r[15:8] <= wd;
                TSR_CMP_H: compare1_value_r[23:16] <= wd;
                default: ;
            endcase
        end
    end

    // control bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_r <= 1'b0;
            auto_reload_mode_r <= 1'b0;
            init_select_r <= 1'b0;
            compare1_enable_r <= 1'b0;
        end else if (wr_go && wb_req_i.adr == TSR_CTRL) begin
            run_r <= wd[TSR_CTL_RUN];
            auto_reload_mode_r <= wd[TSR_CTL_AUTO];
            init_select_r <= wd[TSR_CTL_INIT];
            compare1_enable_r <= wd[TSR_CTL_CMP1EN];
        end
    end

    // snapshot trigger control, strobes self-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            snap_zero_sw_select_r <= 1'b0;
            snap_one_sw_select_r <= 1'b0;
            snap_zero_strobe_r <= 1'b0;
            snap_one_strobe_r <= 1'b0;
        end else if (wr_go && wb_req_i.adr == TSR_SSC) begin
            snap_zero_sw_select_r <= wd[TSR_SSC_SEL0];
            snap_one_sw_select_r <= wd[TSR_SSC_SEL1];
            snap_zero_strobe_r <= wd[TSR_SSC_STB0];
            snap_one_strobe_r <= wd[TSR_SSC_STB1];
        end else begin
            snap_zero_strobe_r <= 1'b0;
            snap_one_strobe_r <= 1'b0;
        end
    end

    tsr_counter #(.W(CW)) u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run_r),
        .auto_i(auto_reload_mode_r),
        .init_i(init_go),
        .init_sel_i(init_select_r),
        .reload_i(reload_value_r),
        .count_o(timer_count)
    );

    tsr_snap #(.W(CW)) u_snap0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .irq_i(ext_irq_zero_i),
        .sw_sel_i(snap_zero_sw_select_r),
        .sw_stb_i(snap_zero_strobe_r),
        .count_i(timer_count),
        .snap_o(snapshot_zero),
        .cap_o(cap0)
    );

    tsr_snap #(.W(CW)) u_snap1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .irq_i(ext_irq_one_i),
        .sw_sel_i(snap_one_sw_select_r),
        .sw_stb_i(snap_one_strobe_r),
        .count_i(timer_count),
        .snap_o(snapshot_one),
        .cap_o(cap1)
    );

    // compare one flag, set beats clear
    assign cmp_hit = compare1_enable_r && (timer_count == compare1_value_r);
    assign flag_clr = wr_go && (wb_req_i.adr == TSR_STAT) && wd[TSR_STAT_CMP1F];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare1_match_flag_r <= 1'b0;
        end else if (cmp_hit) begin
            compare1_match_flag_r <= 1'b1;
        end else if (flag_clr) begin
            compare1_match_flag_r <= 1'b0;
        end
    end
    assign timer_irq_o = compare1_match_flag_r;
    assign timer_count_o = timer_count;

    property p_cmp_set;
        @(posedge clk_i) disable iff (rst_i) cmp_hit |=> compare1_match_flag_r && timer_irq_o;
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("compare flag not set");
    property p_cmp_sticky;
        @(posedge clk_i) disable iff (rst_i)
            (compare1_match_flag_r && !flag_clr) |=> compare1_match_flag_r;
    endproperty
    a_cmp_sticky: assert property (p_cmp_sticky) else $error("flag dropped");
    property p_sw_cap0;
        @(posedge clk_i) disable iff (rst_i)
            (wr_go && wb_req_i.adr == TSR_SSC && wd[TSR_SSC_STB0] && wd[TSR_SSC_SEL0])
            |=> cap0 ##1 snapshot_zero == $past(timer_count);
    endproperty
    a_sw_cap0: assert property (p_sw_cap0) else $error("sw capture zero failed");
    property p_sw_cap1;
        @(posedge clk_i) disable iff (rst_i)
            (wr_go && wb_req_i.adr == TSR_SSC && wd[TSR_SSC_STB1] && wd[TSR_SSC_SEL1])
            |=> cap1 ##1 snapshot_one == $past(timer_count);
    endproperty
    a_sw_cap1: assert property (p_sw_cap1) else $error("sw capture one failed");
    property p_strobe_clear;
        @(posedge clk_i) disable iff (rst_i) snap_zero_strobe_r |=> !snap_zero_strobe_r;
    endproperty
    a_strobe_clear: assert property (p_strobe_clear) else $error("strobe stuck");
    property p_mid_ro;
        @(posedge clk_i) disable iff (rst_i)
            (wr_go && wb_req_i.adr == TSR_CNT_M && !run_r) |=> $stable(timer_count);
    endproperty
    a_mid_ro: assert property (p_mid_ro) else $error("mid byte write changed count");
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) ack_r |=> !ack_r;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_rd_cnt;
        @(posedge clk_i) disable iff (rst_i)
            (rd_go && wb_req_i.adr == TSR_CNT_L) |=> wb_rsp_o.dat[7:0] == $past(timer_count[7:0]);
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("count read stale");

    // bus answer
    property p_ack_answer;
        @(posedge clk_i) disable iff (rst_i)
            (wb_req_i.cyc && wb_req_i.stb && !ack_r) |=> ack_r;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack missing");

    // count load through the low byte
    property p_init_zero;
        @(posedge clk_i) disable iff (rst_i)
            (init_go && !init_select_r) |=> timer_count == '0;
    endproperty
    a_init_zero: assert property (p_init_zero) else $error("init to zero failed");

    property p_init_reload;
        @(posedge clk_i) disable iff (rst_i)
            (init_go && init_select_r) |=> timer_count == $past(reload_value_r);
    endproperty
    a_init_reload: assert property (p_init_reload) else $error("init to reload failed");

    property p_high_ro;
        @(posedge clk_i) disable iff (rst_i)
            (wr_go && wb_req_i.adr == TSR_CNT_H && !run_r) |=> $stable(timer_count);
    endproperty
    a_high_ro: assert property (p_high_ro) else $error("high byte write changed count");

    // value byte writes
    property p_rl_wr;
        @(posedge clk_i) disable iff (rst_i)
            (wr_go && wb_req_i.adr == TSR_RL_H) |=> reload_value_r[23:16] == $past(wd);
    endproperty
    a_rl_wr: assert property (p_rl_wr) else $error("reload byte not written");

    property p_cmp_wr;
        @(posedge clk_i) disable iff (rst_i)
            (wr_go && wb_req_i.adr == TSR_CMP_L) |=> compare1_value_r[7:0] == $past(wd);
    endproperty
    a_cmp_wr: assert property (p_cmp_wr) else $error("compare byte not written");

    property p_flag_clear;
        @(posedge clk_i) disable iff (rst_i)
            (flag_clr && !cmp_hit) |=> !compare1_match_flag_r;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    // snapshot triggers
    property p_hw_cap0;
        @(posedge clk_i) disable iff (rst_i)
            ($rose(ext_irq_zero_i) && !snap_zero_sw_select_r) |=>
            snapshot_zero == $past(timer_count);
    endproperty
    a_hw_cap0: assert property (p_hw_cap0) else $error("hw capture zero failed");

    property p_hw_cap1;
        @(posedge clk_i) disable iff (rst_i)
            ($rose(ext_irq_one_i) && !snap_one_sw_select_r) |=>
            snapshot_one == $past(timer_count);
    endproperty
    a_hw_cap1: assert property (p_hw_cap1) else $error("hw capture one failed");

    property p_hw_once0;
        @(posedge clk_i) disable iff (rst_i)
            (ext_irq_zero_i && $past(ext_irq_zero_i) && !snap_zero_sw_select_r) |=>
            $stable(snapshot_zero);
    endproperty
    a_hw_once0: assert property (p_hw_once0) else $error("level captured twice");

    property p_sw_only0;
        @(posedge clk_i) disable iff (rst_i)
            (snap_zero_sw_select_r && !snap_zero_strobe_r) |=> $stable(snapshot_zero);
    endproperty
    a_sw_only0: assert property (p_sw_only0) else $error("snapshot zero moved");

    property p_sw_only1;
        @(posedge clk_i) disable iff (rst_i)
            (snap_one_sw_select_r && !snap_one_strobe_r) |=> $stable(snapshot_one);
    endproperty
    a_sw_only1: assert property (p_sw_only1) else $error("snapshot one moved");

    property p_strobe1_clear;
        @(posedge clk_i) disable iff (rst_i) snap_one_strobe_r |=> !snap_one_strobe_r;
    endproperty
    a_strobe1_clear: assert property (p_strobe1_clear) else $error("strobe one stuck");

    c_init: cover property (@(posedge clk_i) disable iff (rst_i) init_go && init_select_r);
    c_cmp: cover property (@(posedge clk_i) disable iff (rst_i) cmp_hit);
    c_cap1: cover property (@(posedge clk_i) disable iff (rst_i) cap1);
endmodule // tsr_top
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tsr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    tsr_wb_req_t wb_req = '0;
    tsr_wb_rsp_t wb_rsp_o;
    logic ext_irq_zero_i = 1'b0;
    logic ext_irq_one_i = 1'b0;
    logic timer_irq_o;
    logic [23:0] timer_count_o;
    int fails = 0;
    int samples_checked = 0;
    logic [15:0] reg_list [18] = '{TSR_CMP_L, TSR_CMP_M, TSR_CMP_H, TSR_CTRL, TSR_STAT, TSR_CNT_L,
        TSR_CNT_M, TSR_CNT_H, TSR_RL_L, TSR_RL_M, TSR_RL_H, TSR_SS0_L, TSR_SS0_M, TSR_SS0_H,
        TSR_SS1_L, TSR_SS1_M, TSR_SS1_H, TSR_SSC};

    always #5 clk_i = ~clk_i;

    tsr_top #(.CW(24)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp_o),
        .ext_irq_zero_i(ext_irq_zero_i), .ext_irq_one_i(ext_irq_one_i),
        .timer_irq_o(timer_irq_o), .timer_count_o(timer_count_o));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle, held until ack is sampled high at a rising edge
    task automatic wb_cycle(input logic we, input logic [15:0] adr, input logic [7:0] wd,
                            output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h00_0000, wd}};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_rsp_o.ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("FAIL at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
        end
        rd = wb_rsp_o.dat[7:0];
        wb_req <= '0;
    endtask

    task automatic wr(input logic [15:0] adr, input logic [7:0] wd);
        logic [7:0] d;
        wb_cycle(1'b1, adr, wd, d);
    endtask

    task automatic rd_chk(input logic [15:0] adr, input logic [7:0] exp);
        logic [7:0] d;
        wb_cycle(1'b0, adr, 8'h00, d);
        check({24'h00_0000, d}, {24'h00_0000, exp});
    endtask

    task automatic wr24(input logic [15:0] base, input logic [23:0] v);
        for (int i = 0; i < 3; i++) wr(base + 16'(i), v[8*i +: 8]);
    endtask

    task automatic rd24(input logic [15:0] base, input logic [23:0] exp);
        for (int i = 0; i < 3; i++) rd_chk(base + 16'(i), exp[8*i +: 8]);
    endtask

    // load the stopped count through the low byte with init select at one
    task automatic load_count(input logic [23:0] v);
        wr24(TSR_RL_L, v);
        wr(TSR_CTRL, 8'h04);
        wr(TSR_CNT_L, 8'h5a);
    endtask

    task automatic t_reset();
        foreach (reg_list[i]) rd_chk(reg_list[i], 8'h00);
    endtask

    task automatic t_regs();
        wr24(TSR_RL_L, 24'h12_3456);
        rd24(TSR_RL_L, 24'h12_3456);
        wr24(TSR_CMP_L, 24'h65_4321);
        rd24(TSR_CMP_L, 24'h65_4321);
        wr(16'ha108, 8'h5a);
        rd_chk(16'ha108, 8'h00);
    endtask

    task automatic t_init();
        wr(TSR_CTRL, 8'h04);
        wr(TSR_CNT_L, 8'h99);
        rd24(TSR_CNT_L, 24'h12_3456);
        check({8'h00, timer_count_o}, 32'h0012_3456);
        wr(TSR_CNT_M, 8'haa);
        wr(TSR_CNT_H, 8'hbb);
        rd24(TSR_CNT_L, 24'h12_3456);
        wr(TSR_CTRL, 8'h00);
        wr(TSR_CNT_L, 8'h77);
        rd24(TSR_CNT_L, 24'h00_0000);
    endtask

    task automatic t_sw_snap();
        load_count(24'h12_3456);
        wr(TSR_SSC, 8'h30);
        rd_chk(TSR_SSC, 8'h30);
        wr(TSR_SSC, 8'hb0);
        rd24(TSR_SS0_L, 24'h12_3456);
        rd24(TSR_SS1_L, 24'h00_0000);
        rd_chk(TSR_SSC, 8'h30);
        load_count(24'h0a_0b0c);
        wr(TSR_SSC, 8'h70);
        rd24(TSR_SS1_L, 24'h0a_0b0c);
        rd24(TSR_SS0_L, 24'h12_3456);
        wr(TSR_SSC, 8'hc0);
        rd24(TSR_SS0_L, 24'h12_3456);
        rd24(TSR_SS1_L, 24'h0a_0b0c);
    endtask

    task automatic t_irq_snap();
        load_count(24'h11_2233);
        @(posedge clk_i);
        ext_irq_zero_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd24(TSR_SS0_L, 24'h11_2233);
        rd24(TSR_SS1_L, 24'h0a_0b0c);
        wr(TSR_CTRL, 8'h01);
        repeat (10) @(posedge clk_i);
        wr(TSR_CTRL, 8'h04);
        rd24(TSR_SS0_L, 24'h11_2233);
        ext_irq_zero_i <= 1'b0;
        wr(TSR_SSC, 8'h10);
        @(posedge clk_i);
        ext_irq_one_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        ext_irq_one_i <= 1'b0;
        rd24(TSR_SS1_L, 24'h0a_0b0c);
        wr(TSR_SSC, 8'h00);
        load_count(24'h44_5566);
        @(posedge clk_i);
        ext_irq_one_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        ext_irq_one_i <= 1'b0;
        rd24(TSR_SS1_L, 24'h44_5566);
    endtask

    task automatic t_auto();
        int n;
        for (int m = 0; m < 2; m++) begin
            n = 0;
            load_count(24'hff_fffc);
            wr(TSR_CTRL, (m == 0) ? 8'h07 : 8'h05);
            do begin
                @(negedge clk_i);
                n++;
            end while (timer_count_o !== 24'hff_ffff && n < 40);
            @(negedge clk_i);
            check({8'h00, timer_count_o}, (m == 0) ? 32'h00ff_fffc : 32'h0000_0000);
            wr(TSR_CTRL, 8'h04);
        end
    endtask

    task automatic t_cmp();
        int n;
        n = 0;
        wr24(TSR_CMP_L, 24'h00_0010);
        wr(TSR_CTRL, 8'h00);
        wr(TSR_CNT_L, 8'h00);
        wr(TSR_CTRL, 8'h01);
        repeat (40) @(posedge clk_i);
        wr(TSR_CTRL, 8'h00);
        rd_chk(TSR_STAT, 8'h00);
        check({31'h0, timer_irq_o}, 32'h0);
        wr(TSR_CNT_L, 8'h00);
        wr(TSR_CTRL, 8'h09);
        do begin
            @(negedge clk_i);
            n++;
        end while (timer_irq_o !== 1'b1 && n < 100);
        check({31'h0, timer_irq_o}, 32'h1);
        wr(TSR_CTRL, 8'h08);
        rd_chk(TSR_STAT, 8'h01);
        wr(TSR_STAT, 8'h01);
        rd_chk(TSR_STAT, 8'h00);
        check({31'h0, timer_irq_o}, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_init();
        t_sw_snap();
        t_irq_snap();
        t_auto();
        t_cmp();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        summarize();
    end
endmodule // tb
`default_nettype wire
